// File: rtl/sensor_bus_pkg.sv
package sensor_bus_pkg;

  // ==========================================================
  // Word format
  localparam int WORD_W = 20;
  localparam int ADDR_W = 4;
  localparam int CRC_W = 4;
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;

  // ==========================================================
  // Command codes (low nibble of the command field)
  localparam logic [3:0] CMD_CLEAR = 4'h7;
  localparam logic [3:0] CMD_CLR_OUT = 4'hC;
  localparam logic [3:0] CMD_SET_OUT = 4'hD;
  localparam logic [3:0] CMD_REV_INIT = 4'hF;

  // ==========================================================
  // Field positions in a received long word (CRC already stripped)
  localparam int POS_CMD = 0;
  localparam int POS_ADDR = 4;
  localparam int POS_NEWADDR = 8;
  localparam int POS_GROUP = 12;
  localparam int POS_SWITCH = 14;
  localparam int POS_PERMIT = 15;

  // ==========================================================
  // Timing: fault test lasts about 200 us at 50 MHz
  localparam int CLK_MHZ = 50;
  localparam int FAULT_TEST_US = 200;
  localparam int FAULT_TEST_CYC = FAULT_TEST_US * CLK_MHZ;
  localparam int FT_CNT_W = 14;

  // ==========================================================
  // Reset values
  localparam logic [3:0] RST_ADDR = 4'h0;
  localparam logic RST_LEVEL = 1'b0;

  typedef struct packed {
    logic [15:0] bits;
    logic valid;
  } resp_t;

  typedef struct packed {
    logic undervoltage;
    logic [3:0] pins;
    logic up_fault;
    logic down_fault;
    logic up_active;
    logic down_active;
  } sense_t;

  typedef enum logic [1:0] {
    FT_IDLE,
    FT_RUN,
    FT_DONE
  } ft_state_t;

  // CRC-4 step over one data bit, polynomial x^4+x+1
  function automatic logic [3:0] crc4_step(input logic [3:0] crc,
                                           input logic din);
    logic fb;
    fb = crc[3] ^ din;
    crc4_step = {crc[2], crc[1], crc[0] ^ fb, fb};
  endfunction

endpackage

// File: rtl/resp_hold.sv
`timescale 1ns/1ps
module resp_hold import sensor_bus_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input resp_t load_val,
  input wire logic take,
  input wire logic drop,
  output resp_t cur_q
);
  // ==========================================================
  // Pending response: the answer built at a command's frame end
  // is what goes out during the very next message; a corrupted
  // frame leaves nothing pending, so that message stays silent
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_q <= '0;
    end else if (take) begin
      cur_q <= (load && !drop) ? load_val : resp_t'('0);
    end
  end
endmodule // resp_hold

// File: rtl/fault_tester.sv
`timescale 1ns/1ps
module fault_tester import sensor_bus_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic sense_fault,
  output logic busy_q,
  output logic done_q,
  output logic fault_q
);
  // ==========================================================
  // One timed test: fault latched if seen at any time in window
  ft_state_t st_q;
  logic [FT_CNT_W-1:0] cnt_q;
  localparam logic [FT_CNT_W-1:0] LAST =
    FT_CNT_W'(FAULT_TEST_CYC - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= FT_IDLE;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        FT_IDLE: begin
          if (start) begin
            st_q <= FT_RUN;
            cnt_q <= '0;
            busy_q <= 1'b1;
            fault_q <= 1'b0;
          end
        end
        FT_RUN: begin
          if (sense_fault) fault_q <= 1'b1;
          if (cnt_q == LAST) begin
            st_q <= FT_DONE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: st_q <= FT_DONE;
      endcase
    end
  end
endmodule // fault_tester

// File: rtl/sensor_bus_slave.sv
`timescale 1ns/1ps
// Contract
// - Set-output command drives logic output high
// - Output low after reset and Clear
// - Set-output status returned next message
// - No response when command address zero
// - Status bits show undervoltage, output, switch
// - Reverse init only once until cleared
// - Group bits unused, returned as zero
// - Address-zero init taken by open-switch device
// - Close switch only if requested and fault-free
// - Latch write permit unless address stored
// - Reverse-init response layout, long word only
// - Bus fault flag on upstream short
// - Reply sent during the following message
// - Words separated by minimum frame delay
// - Corrupted frame suppresses next response
// - Fault test once, about 200 us
// - Test upstream port on reverse init
// - Test regardless of stored address
// - Skip test when both ports active
// - Clear opens switch, resets registers silently
// - Global-address init keeps switch open
module sensor_bus_slave import sensor_bus_pkg::*; (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic RX_BIT,
  input wire logic RX_BIT_EN,
  input wire logic RX_FRAME_END,
  input wire logic RX_LONG,
  input wire logic RX_CRC_OK,
  input wire logic TX_BIT_EN,
  input wire logic NVM_STORED,
  input wire logic UNDERVOLTAGE,
  input wire logic [3:0] IO_PINS,
  input wire logic UPSTREAM_FAULT,
  input wire logic DOWNSTREAM_FAULT,
  input wire logic UPSTREAM_ACTIVE,
  input wire logic DOWNSTREAM_ACTIVE,
  output logic TX_BIT,
  output logic TX_VALID,
  output logic DRIVEN_OUTPUT_LEVEL,
  output logic BUS_SWITCH_CLOSE,
  output logic FAULT_TEST_ACTIVE,
  output logic NVM_WRITE_PERMIT,
  output logic BUS_FAULT_FLAG,
  output logic INITIALIZED,
  output logic [3:0] NODE_ADDRESS
);

  // ==========================================================
  // Pin synchronisers: the analog-side levels come from outside
  sense_t sense_raw;
  sense_t sense_m_q;
  sense_t sense_q;

  assign sense_raw = '{undervoltage: UNDERVOLTAGE, pins: IO_PINS,
                       up_fault: UPSTREAM_FAULT,
                       down_fault: DOWNSTREAM_FAULT,
                       up_active: UPSTREAM_ACTIVE,
                       down_active: DOWNSTREAM_ACTIVE};

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sense_m_q <= '0;
      sense_q <= '0;
    end else begin
      sense_m_q <= sense_raw;
      sense_q <= sense_m_q;
    end
  end

  // ==========================================================
  // Receive shift register; the framer reports CRC and length
  logic [WORD_W-1:0] rx_sh_q;
  logic [WORD_W-CRC_W-1:0] word;
  logic frame_ok;
  logic frame_bad;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) rx_sh_q <= '0;
    else if (RX_BIT_EN) rx_sh_q <= {rx_sh_q[WORD_W-2:0], RX_BIT};
  end

  assign word = RX_LONG ? rx_sh_q[WORD_W-1:CRC_W]
                        : {8'h00, rx_sh_q[WORD_W-9:CRC_W]};
  assign frame_ok = RX_FRAME_END && RX_CRC_OK;
  assign frame_bad = RX_FRAME_END && !RX_CRC_OK;

  // ==========================================================
  // Field decode
  logic [3:0] f_cmd;
  logic [3:0] f_addr;
  logic [3:0] f_new;
  logic f_switch;
  logic f_permit;
  logic addr_hit;
  logic is_clear;
  logic is_set;
  logic is_clr_out;
  logic is_rinit;
  logic rinit_take;
  logic rinit_global;

  assign f_cmd = word[POS_CMD +: 4];
  assign f_addr = word[POS_ADDR +: ADDR_W];
  assign f_new = word[POS_NEWADDR +: ADDR_W];
  assign f_switch = word[POS_SWITCH];
  assign f_permit = word[POS_PERMIT];

  logic [3:0] addr_q;
  logic init_q;
  logic level_q;
  logic switch_q;
  logic permit_q;
  logic fault_flag_q;
  logic want_close_q;

  assign addr_hit = f_addr == addr_q;
  assign is_clear = frame_ok && f_cmd == CMD_CLEAR &&
                    (addr_hit || f_addr == ADDR_GLOBAL);
  assign is_set = frame_ok && f_cmd == CMD_SET_OUT && addr_hit;
  assign is_clr_out = frame_ok && f_cmd == CMD_CLR_OUT && addr_hit;
  // Only an uninitialised device with its switch open accepts it
  assign rinit_take = frame_ok && RX_LONG && f_cmd == CMD_REV_INIT &&
                      !init_q && !switch_q;
  assign rinit_global = f_new == ADDR_GLOBAL;

  // ==========================================================
  // Bus fault test; loop-back (both ports live) skips it
  logic ft_start;
  logic ft_skip;
  logic ft_busy;
  logic ft_done;
  logic ft_fault;

  assign ft_skip = sense_q.up_active && sense_q.down_active;
  // Test on every accepted non-global init with switch bit unless looped back, stored NVM or not
  assign ft_start = rinit_take && !rinit_global && f_switch &&
                    !ft_skip;

  fault_tester u_ft (
    .clk(CLOCK),
    .rst(SYS_RST || is_clear),
    .start(ft_start),
    .sense_fault(sense_q.up_fault),
    .busy_q(ft_busy),
    .done_q(ft_done),
    .fault_q(ft_fault)
  );

  // ==========================================================
  // Device state
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || is_clear) begin
      addr_q <= RST_ADDR;
      init_q <= 1'b0;
      level_q <= RST_LEVEL;
      switch_q <= 1'b0;
      permit_q <= 1'b0;
      fault_flag_q <= 1'b0;
      want_close_q <= 1'b0;
    end else begin
      if (is_set) level_q <= 1'b1;
      else if (is_clr_out) level_q <= 1'b0;
      if (rinit_take) begin
        init_q <= 1'b1;
        addr_q <= f_new;
        // Global init stores neither switch nor permit bit
        permit_q <= !rinit_global && f_permit && !NVM_STORED;
        want_close_q <= !rinit_global && f_switch;
        if (!rinit_global && f_switch && ft_skip) switch_q <= 1'b1;
      end
      if (ft_done) begin
        fault_flag_q <= ft_fault;
        if (want_close_q && !ft_fault) switch_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Response build; group bits always zero
  logic [15:0] status_w;
  logic [15:0] rinit_w;
  resp_t load_val;
  logic load;
  logic [3:0] new_addr;
  logic new_permit;
  logic new_level;

  assign new_addr = rinit_take ? f_new : addr_q;
  assign new_permit = !rinit_global && f_permit && !NVM_STORED;
  assign new_level = is_set ? 1'b1 : (is_clr_out ? 1'b0 : level_q);
  assign status_w = {addr_q, 4'h0, permit_q, sense_q.undervoltage,
                     new_level, switch_q, sense_q.pins};
  // Fault flag is refreshed when the test ends; BS reports request
  assign rinit_w = {new_addr, 3'b000, 1'b0, new_permit,
                    !rinit_global && f_switch, 2'b00, f_new};
  // Address zero never answers
  assign load = frame_ok && f_addr != ADDR_GLOBAL &&
                (is_set || is_clr_out || rinit_take) &&
                !(rinit_take && rinit_global);
  assign load_val = '{bits: rinit_take ? rinit_w : status_w,
                      valid: 1'b1};

  // ==========================================================
  // Pending buffer: next message carries it unless corrupted
  resp_t cur;

  resp_hold u_hold (
    .clk(CLOCK),
    .rst(SYS_RST || is_clear),
    .load(load),
    .load_val(load_val),
    .take(RX_FRAME_END),
    .drop(frame_bad),
    .cur_q(cur)
  );

  // ==========================================================
  // Transmit: 16 data bits then CRC, shifted on framer strobes.
  // Short words get no special case: bit 15 goes first; framer decides length.
  logic [4:0] tx_idx_q;
  logic [3:0] tx_crc_q;
  logic tx_data_bit;
  logic tx_in_crc;

  assign tx_in_crc = tx_idx_q >= 5'd16;
  assign tx_data_bit = tx_in_crc ? tx_crc_q[3] :
                       cur.bits[4'(5'd15 - tx_idx_q)];

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || RX_FRAME_END) begin
      tx_idx_q <= '0;
      tx_crc_q <= '0;
    end else if (TX_BIT_EN && cur.valid) begin
      if (tx_in_crc) tx_crc_q <= {tx_crc_q[2:0], 1'b0};
      else tx_crc_q <= crc4_step(tx_crc_q, tx_data_bit);
      if (tx_idx_q != 5'd19) tx_idx_q <= tx_idx_q + 1'b1;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      TX_BIT <= 1'b0;
      TX_VALID <= 1'b0;
      DRIVEN_OUTPUT_LEVEL <= RST_LEVEL;
      BUS_SWITCH_CLOSE <= 1'b0;
      FAULT_TEST_ACTIVE <= 1'b0;
      NVM_WRITE_PERMIT <= 1'b0;
      BUS_FAULT_FLAG <= 1'b0;
      INITIALIZED <= 1'b0;
      NODE_ADDRESS <= RST_ADDR;
    end else begin
      TX_BIT <= cur.valid && tx_data_bit;
      TX_VALID <= cur.valid;
      DRIVEN_OUTPUT_LEVEL <= level_q;
      BUS_SWITCH_CLOSE <= switch_q;
      FAULT_TEST_ACTIVE <= ft_busy;
      NVM_WRITE_PERMIT <= permit_q;
      BUS_FAULT_FLAG <= fault_flag_q;
      INITIALIZED <= init_q;
      NODE_ADDRESS <= addr_q;
    end
  end

endmodule // sensor_bus_slave

// File: tb/slave_check_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module slave_check import sensor_bus_pkg::*; (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic RX_BIT,
  input wire logic RX_BIT_EN,
  input wire logic RX_FRAME_END,
  input wire logic RX_CRC_OK,
  input wire logic NVM_STORED,
  input wire logic UPSTREAM_ACTIVE,
  input wire logic DOWNSTREAM_ACTIVE,
  input wire logic TX_VALID,
  input wire logic DRIVEN_OUTPUT_LEVEL,
  input wire logic BUS_SWITCH_CLOSE,
  input wire logic FAULT_TEST_ACTIVE,
  input wire logic NVM_WRITE_PERMIT,
  input wire logic BUS_FAULT_FLAG,
  input wire logic [3:0] NODE_ADDRESS
);
  logic [11:0] sh_q;
  logic [13:0] cnt_q;
  // Address and command sit above the four check bits of the last word
  wire [3:0] cmd = sh_q[7:4];
  wire [3:0] adr = sh_q[11:8];
  wire good = RX_FRAME_END && RX_CRC_OK;
  wire mine = good && adr != 4'h0 && adr == NODE_ADDRESS;
  wire mute = RX_FRAME_END && (!RX_CRC_OK || adr == 4'h0 || cmd == CMD_CLEAR);
  always_ff @(posedge CLOCK) begin
    sh_q <= SYS_RST ? 12'h000 : RX_BIT_EN ? {sh_q[10:0], RX_BIT} : sh_q;
    cnt_q <= FAULT_TEST_ACTIVE ? cnt_q + 14'h1 : 14'h0;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  reset_quiet_a:
    assert property (disable iff (1'b0) SYS_RST |=> !DRIVEN_OUTPUT_LEVEL
      && !BUS_SWITCH_CLOSE && !TX_VALID) else $error("reset not quiet");
  set_level_a:
    assert property (mine && cmd == CMD_SET_OUT |-> ##2 DRIVEN_OUTPUT_LEVEL)
      else $error("output not set");
  clr_level_a:
    assert property (mine && cmd == CMD_CLR_OUT |-> ##2 !DRIVEN_OUTPUT_LEVEL)
      else $error("output not cleared");
  reply_next_a:
    assert property (mine && (cmd == CMD_SET_OUT || cmd == CMD_CLR_OUT)
      |-> ##2 TX_VALID) else $error("reply missing");
  no_reply_a:
    assert property (mute |-> ##2 !TX_VALID) else $error("reply not muted");
  clear_open_a:
    assert property (good && cmd == CMD_CLEAR && (adr == 4'h0 ||
      adr == NODE_ADDRESS) |-> ##2 !BUS_SWITCH_CLOSE && !DRIVEN_OUTPUT_LEVEL
      && NODE_ADDRESS == RST_ADDR) else $error("clear incomplete");
  test_len_a:
    assert property ($fell(FAULT_TEST_ACTIVE) |-> cnt_q == 14'(FAULT_TEST_CYC))
      else $error("fault test length wrong");
  fault_block_a:
    assert property ($rose(BUS_SWITCH_CLOSE) |-> !BUS_FAULT_FLAG
      && !FAULT_TEST_ACTIVE) else $error("switch closed unsafely");
  loop_skip_a:
    assert property (UPSTREAM_ACTIVE && DOWNSTREAM_ACTIVE &&
      $past(UPSTREAM_ACTIVE, 3) && $past(DOWNSTREAM_ACTIVE, 3)
      |-> !$rose(FAULT_TEST_ACTIVE)) else $error("loop-back test ran");
  permit_lock_a:
    assert property (NVM_STORED && !NVM_WRITE_PERMIT |=> !NVM_WRITE_PERMIT)
      else $error("permit set after store");
  cover property (mine && cmd == CMD_SET_OUT);
  cover property ($fell(FAULT_TEST_ACTIVE));
  cover property (RX_FRAME_END && !RX_CRC_OK);
endmodule // slave_check

bind sensor_bus_slave slave_check i_check (.CLOCK, .SYS_RST, .RX_BIT,
  .RX_BIT_EN, .RX_FRAME_END, .RX_CRC_OK, .NVM_STORED, .UPSTREAM_ACTIVE,
  .DOWNSTREAM_ACTIVE, .TX_VALID, .DRIVEN_OUTPUT_LEVEL, .BUS_SWITCH_CLOSE,
  .FAULT_TEST_ACTIVE, .NVM_WRITE_PERMIT, .BUS_FAULT_FLAG, .NODE_ADDRESS);

// File: tb/bus_master_model.sv
`timescale 1ns/1ps
// ==========================================================
// Bus master: sends one word and collects the reply in the same message
module bus_master_model import sensor_bus_pkg::*; (
  input wire logic clk,
  input wire logic tx_bit,
  input wire logic tx_valid,
  output logic rx_bit,
  output logic rx_bit_en,
  output logic rx_frame_end,
  output logic rx_long,
  output logic rx_crc_ok,
  output logic tx_bit_en
);
  initial begin
    {rx_bit, rx_bit_en, rx_frame_end, rx_crc_ok, tx_bit_en} = '0;
    rx_long = 1'b1;
  end
  // Full duplex: reply bit is taken before the same pulse advances it
  task automatic send(input logic [15:0] w, input logic ok,
      output resp_t r, output logic [3:0] c);
    logic [19:0] tw;
    logic [19:0] got;
    tw = {w, 4'h0};
    @(negedge clk);
    r.valid = tx_valid;
    for (int i = 19; i >= 0; i--) begin
      got[i] = tx_bit;
      rx_bit = tw[i];
      rx_bit_en = 1'b1;
      tx_bit_en = 1'b1;
      @(negedge clk);
      rx_bit_en = 1'b0;
      tx_bit_en = 1'b0;
      @(negedge clk);
    end
    rx_frame_end = 1'b1;
    rx_crc_ok = ok;
    @(negedge clk);
    rx_frame_end = 1'b0;
    rx_bit = ~rx_bit;
    repeat (4) @(negedge clk);
    r.bits = got[19:4];
    c = got[3:0];
  endtask
endmodule // bus_master_model

// File: tb/test_sensor_bus_slave.sv
`timescale 1ns/1ps
module test_sensor_bus_slave import sensor_bus_pkg::*;;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic nvm_stored = 1'b0, uv = 1'b0, up_f = 1'b0, dn_f = 1'b0;
  logic up_a = 1'b0, dn_a = 1'b0;
  logic [3:0] io = 4'h0;
  logic rx_bit, rx_bit_en, rx_frame_end, rx_long, rx_crc_ok, tx_bit_en;
  logic tx_bit, tx_valid, lvl, sw, fta, permit, bf, init_o;
  logic [3:0] node;
  logic [3:0] c;
  resp_t r;
  int error_cnt = 0;
  int total_checks = 0;
  wire [11:0] st = {init_o, bf, fta, lvl, sw, permit, 2'b00, node};
  always #10 clock = ~clock;
  sensor_bus_slave i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .RX_BIT(rx_bit),
    .RX_BIT_EN(rx_bit_en), .RX_FRAME_END(rx_frame_end), .RX_LONG(rx_long),
    .RX_CRC_OK(rx_crc_ok), .TX_BIT_EN(tx_bit_en), .NVM_STORED(nvm_stored),
    .UNDERVOLTAGE(uv), .IO_PINS(io), .UPSTREAM_FAULT(up_f),
    .DOWNSTREAM_FAULT(dn_f), .UPSTREAM_ACTIVE(up_a), .DOWNSTREAM_ACTIVE(dn_a),
    .TX_BIT(tx_bit), .TX_VALID(tx_valid), .DRIVEN_OUTPUT_LEVEL(lvl),
    .BUS_SWITCH_CLOSE(sw), .FAULT_TEST_ACTIVE(fta), .NVM_WRITE_PERMIT(permit),
    .BUS_FAULT_FLAG(bf), .INITIALIZED(init_o), .NODE_ADDRESS(node));
  bus_master_model i_master (.clk(clock), .tx_bit, .tx_valid, .rx_bit,
    .rx_bit_en, .rx_frame_end, .rx_long, .rx_crc_ok, .tx_bit_en);
  // ==========================================================
  // Checking helpers
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp,
      input string m);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic state(input logic [11:0] e);
    chk(20'(st), 20'(e), "state bits");
  endtask
  function automatic logic [3:0] crc_of(input logic [15:0] d);
    crc_of = 4'h0;
    for (int i = 15; i >= 0; i--)
      crc_of = {crc_of[2:0], 1'b0} ^ ((crc_of[3] ^ d[i]) ? 4'h3 : 4'h0);
  endfunction
  // Presence and content of the reply that travels with this word
  task automatic msg(input logic [15:0] w, input logic ok, input logic v,
      input logic [15:0] e);
    i_master.send(w, ok, r, c);
    chk(20'(r.valid), 20'(v), "reply presence");
    if (v) chk({r.bits, c}, {e, crc_of(e)}, "reply word");
  endtask
  // Waits out the long pull-down test; bounded so a hang ends the run
  task automatic test_wait();
    int n;
    n = 0;
    while (fta !== 1'b0 && n < 12000) begin
      @(negedge clock);
      n++;
    end
    if (n == 12000) begin
      chk(20'h0_0001, 20'h0_0000, "fault test hang");
      final_report();
    end
    repeat (2) @(negedge clock);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    repeat (3) @(negedge clock);
    state(12'h000);
    dn_f = 1'b1;
    uv = 1'b1;
    io = 4'hA;
    msg({4'hC, 4'h5, 4'h0, CMD_REV_INIT}, 1'b1, 1'b0, 16'h0000);
    state(12'hA45);
    test_wait();
    state(12'h8C5);
    msg({8'h08, 4'h5, CMD_SET_OUT}, 1'b1, 1'b0, 16'h0000);
    msg({4'hC, 4'h9, 4'h0, CMD_REV_INIT}, 1'b1, 1'b1, 16'h50FA);
    state(12'h9C5);
    msg({8'h00, 4'h5, CMD_CLR_OUT}, 1'b1, 1'b0, 16'h0000);
    msg({8'h08, 4'h5, CMD_SET_OUT}, 1'b0, 1'b1, 16'h50DA);
    state(12'h8C5);
    msg({8'h08, 4'h5, CMD_SET_OUT}, 1'b1, 1'b0, 16'h0000);
    msg({8'h00, 4'h5, CMD_CLEAR}, 1'b1, 1'b1, 16'h50FA);
    state(12'h000);
    nvm_stored = 1'b1;
    msg({4'h8, 4'h3, 4'h3, CMD_REV_INIT}, 1'b1, 1'b0, 16'h0000);
    state(12'h803);
    msg({8'h00, 4'h3, CMD_CLEAR}, 1'b1, 1'b1, 16'h3003);
    up_f = 1'b1;
    msg({4'h4, 4'h7, 4'h0, CMD_REV_INIT}, 1'b1, 1'b0, 16'h0000);
    test_wait();
    state(12'hC07);
    msg({8'h00, 4'h0, CMD_CLEAR}, 1'b1, 1'b0, 16'h0000);
    up_f = 1'b0;
    up_a = 1'b1;
    dn_a = 1'b1;
    repeat (4) @(negedge clock);
    msg({4'h4, 4'h6, 4'h0, CMD_REV_INIT}, 1'b1, 1'b0, 16'h0000);
    repeat (4) @(negedge clock);
    state(12'h886);
    final_report();
  end
endmodule // test_sensor_bus_slave
